/* File: hw/ebu_pkg.sv */
// Package: constants and types for the emulator break unit
package ebu_pkg;
	localparam int EBU_ADDR_W = 15;
	localparam int EBU_CNT_W = 16;
	localparam int EBU_PRB_W = 8;
	localparam int EBU_RAM_W = 4;
	localparam int EBU_ADDR_LIST = 20;
	localparam int EBU_BREAK_TYPES = 10;
	localparam logic [7:0] EBU_PRB_MASK_DEFAULT = 8'hff;
	localparam logic [3:0] EBU_RAM_MASK_DEFAULT = 4'hf;
	localparam logic [15:0] EBU_CNT_ONE = 16'h0001;
	localparam logic [15:0] EBU_TRACE_ZERO = 16'h0000;
	localparam logic [1:0] EBU_SEQ_ZERO = 2'h0;
	localparam logic [1:0] EBU_SEQ_TWO = 2'h2;
	localparam logic [1:0] EBU_SEQ_THREE = 2'h3;
	// Break types, one code per documented condition
	typedef enum logic [3:0] {
		EBU_BRK_NONE = 4'h0,
		EBU_BRK_ADDR_LIST = 4'h1,
		EBU_BRK_ADDR_RANGE = 4'h2,
		EBU_BRK_ADDR_COUNT = 4'h3,
		EBU_BRK_ADDR_SEQ = 4'h4,
		EBU_BRK_DATA = 4'h5,
		EBU_BRK_DATA_COUNT = 4'h6,
		EBU_BRK_DATA_AT = 4'h7,
		EBU_BRK_DATA_AT_COUNT = 4'h8,
		EBU_BRK_DATA_RANGE = 4'h9,
		EBU_BRK_DATA_RANGE_COUNT = 4'ha
	} ebu_brk_t;
	// Reason reported with a stop
	typedef enum logic [2:0] {
		EBU_ST_NONE = 3'h0,
		EBU_ST_ADDR = 3'h1,
		EBU_ST_DATA = 3'h2,
		EBU_ST_HOST = 3'h3,
		EBU_ST_ALWAYS = 3'h4,
		EBU_ST_NO_STATUS = 3'h5
	} ebu_status_t;
	typedef enum logic [1:0] {
		EBU_RUN_IDLE = 2'b00,
		EBU_RUN_GO = 2'b01,
		EBU_RUN_STOP = 2'b10
	} ebu_run_t;
endpackage : ebu_pkg

/* File: hw/ebu_match_if.sv */
// Interface: address list match between top and matcher
`timescale 1ns/1ns
`default_nettype none
interface ebu_match_if #(
	parameter int ADDR_W = 15,
	parameter int LIST = 20
);
	logic [ADDR_W-1:0] addr;
	logic [LIST-1:0][ADDR_W-1:0] list;
	logic [LIST-1:0] list_valid;
	logic hit;
	modport top (output addr, output list, output list_valid, input hit);
	modport matcher (input addr, input list, input list_valid, output hit);
endinterface : ebu_match_if
`default_nettype wire

/* File: hw/ebu_addr_match.sv */
// Module: compares one address against a list of up to twenty entries
`timescale 1ns/1ns
`default_nettype none
module ebu_addr_match #(
	parameter int ADDR_W = 15,
	parameter int LIST = 20
) (
	ebu_match_if.matcher m
);
	logic [LIST-1:0] eq;
	genvar i;
	generate
		for (i = 0; i < LIST; i++) begin : g_cmp
			assign eq[i] = m.list_valid[i] && (m.list[i] == m.addr);
		end
	endgenerate
	assign m.hit = |eq;
endmodule : ebu_addr_match
`default_nettype wire

/* File: hw/ebu_break_unit.sv */
// Top: break-condition logic for realtime emulation of the core
// Overview of operation
// - Ten break types can be armed to stop continuous execution.
// - With nothing armed, only always-active sources or host abort stop the run.
// - Without a start address the run resumes from the current program counter.
// - A start address clears trace position; otherwise it keeps counting.
// - Data match source is probe pins or one data-memory location.
// - Mask is four bits for memory and eight bits for probe.
// - Mask zero drops a bit, one keeps it; omitted mask is all ones.
// - External user reset passes only while running with switch enabled.
// - A break met during a skip waits for the skip, then reports no status.
// - A break met during interrupt transfer waits for it, then no status.
// - Time-base counters freeze after a break until execution restarts.
// - Individual-address break stops on any of twenty listed addresses.
// - Range break stops on any instruction between lower and upper bound.
// - Pass-count break stops when one address executed count times.
// - Sequence break stops after two or three addresses run in order.
// - Counted data match stops after count masked equalities.
// - Address-qualified data match also needs PC in the twenty-entry list.
// - Range-qualified data match needs PC in range, optionally counted.
// - Memory-sourced data break takes effect one instruction later.
`timescale 1ns/1ns
`default_nettype none
module ebu_break_unit #(
	parameter int ADDR_W = ebu_pkg::EBU_ADDR_W,
	parameter int CNT_W = ebu_pkg::EBU_CNT_W,
	parameter int LIST = ebu_pkg::EBU_ADDR_LIST
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	// Host arming and run control
	input wire logic go_in,
	input wire logic start_valid_in,
	input wire logic [ADDR_W-1:0] start_addr_in,
	input wire ebu_pkg::ebu_brk_t brk_type_in,
	input wire logic [LIST-1:0][ADDR_W-1:0] addr_list_in,
	input wire logic [LIST-1:0] addr_list_valid_in,
	input wire logic [ADDR_W-1:0] range_lo_in,
	input wire logic [ADDR_W-1:0] range_hi_in,
	input wire logic [CNT_W-1:0] count_in,
	input wire logic [1:0] seq_len_in,
	input wire logic probe_pin_source_sel_in,
	input wire logic mask_valid_in,
	input wire logic [7:0] mask_in,
	input wire logic [7:0] data_in,
	input wire logic host_abort_request_in,
	input wire logic always_break_in,
	// Emulated core
	input wire logic insn_done_in,
	input wire logic [ADDR_W-1:0] insn_addr_in,
	input wire logic first_byte_in,
	input wire logic skip_in,
	input wire logic int_xfer_in,
	input wire logic [3:0] ram_data_in,
	// Board pins
	input wire logic [7:0] probe_pin_source_in,
	input wire logic user_reset_pin_in,
	input wire logic reset_switch_in,
	// Results
	output logic running_out,
	output logic load_start_out,
	output logic [ADDR_W-1:0] start_addr_out,
	output logic break_out,
	output ebu_pkg::ebu_status_t break_status_out,
	output logic [ADDR_W-1:0] break_pc_out,
	output logic [CNT_W-1:0] trace_position_out,
	output logic timebase_run_out,
	output logic user_reset_out
);
	typedef struct packed {
		ebu_pkg::ebu_run_t run;
		logic [2:0] prb_s1;
		logic [2:0][7:0] prb_sync;
		logic [2:0] rst_sync;
		logic [7:0] prb_val;
		logic rst_val;
		logic [CNT_W-1:0] count;
		logic [1:0] seq_pos;
		logic data_pend;
		logic defer_pend;
		ebu_pkg::ebu_status_t defer_status;
		logic [CNT_W-1:0] trace;
		logic load_start;
		logic [ADDR_W-1:0] start_addr;
		logic brk;
		ebu_pkg::ebu_status_t status;
		logic [ADDR_W-1:0] brk_pc;
		logic ureset;
	} ebu_state_t;

	ebu_state_t st;
	ebu_state_t next_st;

	ebu_match_if #(.ADDR_W(ADDR_W), .LIST(LIST)) mif ();
	ebu_addr_match #(.ADDR_W(ADDR_W), .LIST(LIST)) u_match (
		.m(mif.matcher)
	);
	assign mif.addr = insn_addr_in;
	assign mif.list = addr_list_in;
	assign mif.list_valid = addr_list_valid_in;

	logic [7:0] mask;
	logic [7:0] src;
	logic data_eq;
	logic in_range;
	logic seq_hit;
	logic addr_cond;
	logic data_cond;
	logic counted;
	logic cond_now;
	logic ram_src;
	logic [1:0] seq_last;

	always_comb begin
		ram_src = !probe_pin_source_sel_in;
		if (mask_valid_in) begin
			mask = ram_src ? {4'h0, mask_in[3:0]} : mask_in;
		end else begin
			mask = ram_src ? {4'h0, ebu_pkg::EBU_RAM_MASK_DEFAULT} : ebu_pkg::EBU_PRB_MASK_DEFAULT;
		end
		src = ram_src ? {4'h0, ram_data_in} : st.prb_val;
		data_eq = ((src ^ data_in) & mask) == 8'h00;
		in_range = (insn_addr_in >= range_lo_in) && (insn_addr_in <= range_hi_in);
		seq_last = (seq_len_in == ebu_pkg::EBU_SEQ_THREE) ? ebu_pkg::EBU_SEQ_TWO : 2'h1;
		seq_hit = addr_list_valid_in[st.seq_pos] && (insn_addr_in == addr_list_in[st.seq_pos]);
		addr_cond = 1'b0;
		data_cond = 1'b0;
		counted = 1'b0;
		unique case (brk_type_in)
			ebu_pkg::EBU_BRK_NONE: addr_cond = 1'b0;
			ebu_pkg::EBU_BRK_ADDR_LIST: addr_cond = mif.hit;
			ebu_pkg::EBU_BRK_ADDR_RANGE: addr_cond = in_range;
			ebu_pkg::EBU_BRK_ADDR_COUNT: begin
				addr_cond = mif.list_valid[0] && (insn_addr_in == addr_list_in[0]);
				counted = 1'b1;
			end
			ebu_pkg::EBU_BRK_ADDR_SEQ: addr_cond = seq_hit && (st.seq_pos == seq_last);
			ebu_pkg::EBU_BRK_DATA: data_cond = data_eq;
			ebu_pkg::EBU_BRK_DATA_COUNT: begin
				data_cond = data_eq;
				counted = 1'b1;
			end
			ebu_pkg::EBU_BRK_DATA_AT: data_cond = data_eq && mif.hit;
			ebu_pkg::EBU_BRK_DATA_AT_COUNT: begin
				data_cond = data_eq && mif.hit;
				counted = 1'b1;
			end
			ebu_pkg::EBU_BRK_DATA_RANGE: data_cond = data_eq && in_range;
			ebu_pkg::EBU_BRK_DATA_RANGE_COUNT: begin
				data_cond = data_eq && in_range;
				counted = 1'b1;
			end
			default: addr_cond = 1'b0; // Unused codes arm nothing
		endcase
		cond_now = addr_cond || data_cond;
	end

	always_comb begin
		logic evt;
		logic hit;
		logic stop_req;
		ebu_pkg::ebu_status_t why;
		evt = 1'b0;
		hit = 1'b0;
		stop_req = 1'b0;
		why = ebu_pkg::EBU_ST_NONE;
		next_st = st;
		// Three-stage pin synchronisers; a change counts when stages two and three agree
		next_st.prb_sync = {st.prb_sync[1:0], probe_pin_source_in};
		next_st.rst_sync = {st.rst_sync[1:0], user_reset_pin_in};
		if (st.prb_sync[1] == st.prb_sync[2]) begin
			next_st.prb_val = st.prb_sync[2];
		end
		if (st.rst_sync[1] == st.rst_sync[2]) begin
			next_st.rst_val = st.rst_sync[2];
		end
		next_st.prb_s1 = 3'h0;
		next_st.load_start = 1'b0;
		unique case (st.run)
			ebu_pkg::EBU_RUN_IDLE, ebu_pkg::EBU_RUN_STOP: begin
				if (go_in) begin
					next_st.run = ebu_pkg::EBU_RUN_GO;
					next_st.brk = 1'b0;
					next_st.status = ebu_pkg::EBU_ST_NONE;
					next_st.count = count_in;
					next_st.seq_pos = ebu_pkg::EBU_SEQ_ZERO;
					next_st.data_pend = 1'b0;
					next_st.defer_pend = 1'b0;
					next_st.load_start = start_valid_in;
					next_st.start_addr = start_addr_in;
					if (start_valid_in) begin
						next_st.trace = ebu_pkg::EBU_TRACE_ZERO;
					end
				end
			end
			ebu_pkg::EBU_RUN_GO: begin
				if (insn_done_in) begin
					next_st.trace = st.trace + ebu_pkg::EBU_CNT_ONE;
				end
				// Evaluate only at a first-byte boundary of an executed instruction
				evt = insn_done_in && first_byte_in;
				if (evt && brk_type_in == ebu_pkg::EBU_BRK_ADDR_SEQ && seq_hit && st.seq_pos != seq_last) begin
					next_st.seq_pos = st.seq_pos + 2'h1;
				end
				if (evt && cond_now) begin
					if (counted && st.count > ebu_pkg::EBU_CNT_ONE) begin
						next_st.count = st.count - ebu_pkg::EBU_CNT_ONE;
					end else if (data_cond && ram_src) begin
						// Memory write lands late, so stop after the following instruction
						next_st.data_pend = 1'b1;
					end else begin
						hit = 1'b1;
						why = data_cond ? ebu_pkg::EBU_ST_DATA : ebu_pkg::EBU_ST_ADDR;
					end
				end
				if (evt && st.data_pend) begin
					hit = 1'b1;
					why = ebu_pkg::EBU_ST_DATA;
					next_st.data_pend = 1'b0;
				end
				if (host_abort_request_in) begin
					hit = 1'b1;
					why = ebu_pkg::EBU_ST_HOST;
				end else if (always_break_in) begin
					hit = 1'b1;
					why = ebu_pkg::EBU_ST_ALWAYS;
				end
				if (skip_in || int_xfer_in) begin
					if (hit || st.defer_pend) begin
						next_st.defer_pend = 1'b1;
						next_st.defer_status = ebu_pkg::EBU_ST_NO_STATUS;
					end
				end else if (st.defer_pend) begin
					stop_req = 1'b1;
					why = st.defer_status;
					next_st.defer_pend = 1'b0;
				end else begin
					stop_req = hit;
				end
				if (stop_req) begin
					next_st.run = ebu_pkg::EBU_RUN_STOP;
					next_st.brk = 1'b1;
					next_st.status = why;
					next_st.brk_pc = insn_addr_in;
				end
			end
			default: next_st.run = ebu_pkg::EBU_RUN_IDLE;
		endcase
		// Reset pin passes only during a run with the board switch on
		next_st.ureset = (next_st.run == ebu_pkg::EBU_RUN_GO) && reset_switch_in && st.rst_val;
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '0;
		end else if (clk_en_in) begin
			st <= next_st;
		end
	end

	assign running_out = (st.run == ebu_pkg::EBU_RUN_GO);
	assign load_start_out = st.load_start;
	assign start_addr_out = st.start_addr;
	assign break_out = st.brk;
	assign break_status_out = st.status;
	assign break_pc_out = st.brk_pc;
	assign trace_position_out = st.trace;
	// Counters hold from the stop until the next go
	assign timebase_run_out = running_out;
	assign user_reset_out = st.ureset;
endmodule : ebu_break_unit
`default_nettype wire

/* File: test/ebu_break_props.sv */
// Checker: run control, trace and break timing of the break unit
`timescale 1ns/1ns
`default_nettype none
module ebu_break_props #(
	parameter int CNT_W = 16
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	input wire logic go_in,
	input wire logic start_valid_in,
	input wire logic host_abort_request_in,
	input wire logic insn_done_in,
	input wire logic skip_in,
	input wire logic int_xfer_in,
	input wire logic reset_switch_in,
	input wire logic running_out,
	input wire logic load_start_out,
	input wire logic break_out,
	input wire ebu_pkg::ebu_status_t break_status_out,
	input wire logic [CNT_W-1:0] trace_position_out,
	input wire logic timebase_run_out,
	input wire logic user_reset_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	a_go_starts_run: assert property (go_in && clk_en_in && !running_out |=> running_out)
		else $error("run did not start after go");
	a_start_loads: assert property (load_start_out |-> $past(go_in && start_valid_in))
		else $error("start loaded without a start address");
	a_trace_cleared: assert property (load_start_out |-> trace_position_out == 0)
		else $error("trace position not cleared on start");
	a_trace_counts: assert property (running_out && insn_done_in && clk_en_in && !load_start_out
		|=> trace_position_out == $past(trace_position_out) + 1'b1) else $error("trace position did not count");
	a_run_freezes: assert property ($fell(running_out) |-> break_out && !timebase_run_out)
		else $error("run ended without a frozen break");
	a_break_holds: assert property (break_out && !go_in |=> break_out)
		else $error("break released without go");
	a_abort_stops: assert property (running_out && host_abort_request_in && !skip_in && !int_xfer_in
		|=> break_out) else $error("host abort did not stop the run");
	a_defer_skip: assert property ($rose(break_out) && break_status_out != ebu_pkg::EBU_ST_HOST
		&& break_status_out != ebu_pkg::EBU_ST_ALWAYS |-> $past(!skip_in && !int_xfer_in))
		else $error("break raised during skip or transfer");
	a_user_reset_gate: assert property (user_reset_out |-> running_out && $past(reset_switch_in))
		else $error("user reset passed while not allowed");
endmodule : ebu_break_props
bind ebu_break_unit ebu_break_props #(.CNT_W(CNT_W)) ebu_break_props_inst (.core_clk_in, .rst_in, .clk_en_in,
	.go_in, .start_valid_in, .host_abort_request_in, .insn_done_in, .skip_in, .int_xfer_in, .reset_switch_in,
	.running_out, .load_start_out, .break_out, .break_status_out, .trace_position_out, .timebase_run_out,
	.user_reset_out);
`default_nettype wire

/* File: test/ebu_core_model.sv */
// Partner: emulated core retiring one instruction per request
`timescale 1ns/1ns
`default_nettype none
module ebu_core_model (
	input wire logic core_clk_in,
	output logic insn_done_out,
	output logic [14:0] insn_addr_out,
	output logic first_byte_out,
	output logic skip_out,
	output logic int_xfer_out
);
	initial begin
		insn_done_out = 1'b0;
		insn_addr_out = 15'h0000;
		first_byte_out = 1'b0;
		skip_out = 1'b0;
		int_xfer_out = 1'b0;
	end
	// One retire pulse with its fetch address
	task automatic exec(input logic [14:0] a, input logic fb, input logic sk, input logic ix);
		@(posedge core_clk_in);
		insn_done_out <= 1'b1;
		insn_addr_out <= a;
		first_byte_out <= fb;
		skip_out <= sk;
		int_xfer_out <= ix;
		@(posedge core_clk_in);
		insn_done_out <= 1'b0;
		insn_addr_out <= ~a; // Inverted, so no stale address
		first_byte_out <= ~fb;
		@(posedge core_clk_in);
		skip_out <= 1'b0; // Skip or transfer ends a cycle late
		int_xfer_out <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		#1;
	endtask : exec
endmodule : ebu_core_model
`default_nettype wire

/* File: test/tb.sv */
// Testbench: break types, deferral, trace and user reset
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic core_clk_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1, go_in = 1'b0, start_valid_in = 1'b0;
	logic mask_valid_in = 1'b0, host_abort_request_in = 1'b0, always_break_in = 1'b0;
	logic probe_pin_source_sel_in = 1'b0, user_reset_pin_in = 1'b0, reset_switch_in = 1'b0;
	logic [14:0] start_addr_in = 15'h0100, range_lo_in = 15'h0030, range_hi_in = 15'h0032;
	ebu_pkg::ebu_brk_t brk_type_in = ebu_pkg::EBU_BRK_NONE;
	logic [19:0][14:0] addr_list_in = '0;
	logic [19:0] addr_list_valid_in = 20'h8_0001;
	logic [15:0] count_in = 16'h0003;
	logic [1:0] seq_len_in = 2'h3;
	logic [7:0] mask_in = 8'h0f, data_in = 8'h05, probe_pin_source_in = 8'ha5;
	logic [3:0] ram_data_in = 4'h7;
	logic insn_done_in, first_byte_in, skip_in, int_xfer_in;
	logic running_out, load_start_out, break_out, timebase_run_out, user_reset_out;
	logic [14:0] insn_addr_in, start_addr_out, break_pc_out;
	logic [15:0] trace_position_out;
	ebu_pkg::ebu_status_t break_status_out;
	int errors = 0, comparisons = 0;
	ebu_break_unit ebu_break_unit_inst (.*);
	ebu_core_model ebu_core_model_inst (.core_clk_in(core_clk_in), .insn_done_out(insn_done_in),
		.insn_addr_out(insn_addr_in), .first_byte_out(first_byte_in), .skip_out(skip_in),
		.int_xfer_out(int_xfer_in));
	always #4 core_clk_in = ~core_clk_in;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task conclude;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	task automatic go(input ebu_pkg::ebu_brk_t t, input logic sv);
		go_in <= 1'b1;
		start_valid_in <= sv;
		brk_type_in <= t;
		@(posedge core_clk_in);
		go_in <= 1'b0;
		#1;
		chk(running_out, 1);
		chk(load_start_out, sv);
		if (sv) chk(trace_position_out, 0);
	endtask : go
	task automatic ex(input logic [14:0] a, input logic b);
		ebu_core_model_inst.exec(a, 1'b1, 1'b0, 1'b0);
		chk(break_out, b);
	endtask : ex
	task t_addr;
		@(posedge core_clk_in);
		addr_list_in[0] <= 15'h0010;
		addr_list_in[19] <= 15'h0020;
		go(ebu_pkg::EBU_BRK_ADDR_LIST, 1'b1);
		ex(15'h0011, 0);
		ebu_core_model_inst.exec(15'h0020, 1'b0, 1'b0, 1'b0);
		ex(15'h0020, 1);
		chk(break_status_out, ebu_pkg::EBU_ST_ADDR);
		chk(break_pc_out, 15'h0020);
		chk(timebase_run_out, 0);
		chk(trace_position_out, 3);
		@(posedge core_clk_in);
		go(ebu_pkg::EBU_BRK_ADDR_LIST, 1'b0);
		ex(15'h0010, 1);
		chk(trace_position_out, 4);
		@(posedge core_clk_in);
		go(ebu_pkg::EBU_BRK_ADDR_RANGE, 1'b1);
		ex(15'h002f, 0);
		ex(15'h0033, 0);
		ex(15'h0032, 1);
		@(posedge core_clk_in);
		addr_list_in[0] <= 15'h0040;
		go(ebu_pkg::EBU_BRK_ADDR_COUNT, 1'b1);
		ex(15'h0040, 0);
		ex(15'h0041, 0);
		ex(15'h0040, 0);
		ex(15'h0040, 1);
	endtask : t_addr
	task t_seq_data;
		@(posedge core_clk_in);
		addr_list_in[2:0] <= {15'h0052, 15'h0051, 15'h0050};
		addr_list_valid_in <= 20'h0_0007;
		go(ebu_pkg::EBU_BRK_ADDR_SEQ, 1'b1);
		ex(15'h0052, 0);
		ex(15'h0051, 0);
		ex(15'h0050, 0);
		ex(15'h0051, 0);
		ex(15'h0052, 1);
		@(posedge core_clk_in);
		probe_pin_source_sel_in <= 1'b1;
		mask_valid_in <= 1'b1;
		count_in <= 16'h0002;
		go(ebu_pkg::EBU_BRK_DATA_COUNT, 1'b1);
		ex(15'h0001, 0);
		ex(15'h0002, 1);
		chk(break_status_out, ebu_pkg::EBU_ST_DATA);
		@(posedge core_clk_in);
		go(ebu_pkg::EBU_BRK_DATA_AT, 1'b1);
		ex(15'h0060, 0);
		ex(15'h0050, 1);
		@(posedge core_clk_in);
		probe_pin_source_sel_in <= 1'b0;
		mask_valid_in <= 1'b0;
		data_in <= 8'h03;
		go(ebu_pkg::EBU_BRK_DATA, 1'b1);
		ex(15'h0060, 0);
		ex(15'h0061, 0);
		@(posedge core_clk_in);
		ram_data_in <= 4'h3;
		ex(15'h0062, 0);
		ex(15'h0063, 1);
	endtask : t_seq_data
	task t_stops;
		logic [15:0] held;
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk_in);
			brk_type_in <= ebu_pkg::EBU_BRK_ADDR_LIST;
			go(ebu_pkg::EBU_BRK_ADDR_LIST, 1'b1);
			ebu_core_model_inst.exec(15'h0050, 1'b1, i == 0, i == 1);
			chk(break_status_out, ebu_pkg::EBU_ST_NO_STATUS);
			@(posedge core_clk_in);
			go(ebu_pkg::EBU_BRK_NONE, 1'b1);
			ex(15'h0050, 0);
			@(posedge core_clk_in);
			host_abort_request_in <= (i == 0);
			always_break_in <= (i == 1);
			reset_switch_in <= 1'b1;
			user_reset_pin_in <= 1'b1;
			repeat (2) @(posedge core_clk_in);
			#1;
			chk(break_status_out, i ? ebu_pkg::EBU_ST_ALWAYS : ebu_pkg::EBU_ST_HOST);
			repeat (8) @(posedge core_clk_in);
			#1;
			chk(user_reset_out, 0);
			@(posedge core_clk_in);
			host_abort_request_in <= 1'b0;
			always_break_in <= 1'b0;
		end
		go(ebu_pkg::EBU_BRK_NONE, 1'b0);
		repeat (8) @(posedge core_clk_in);
		#1;
		chk(user_reset_out, 1);
		// Enable low must freeze the trace even while instructions retire
		@(posedge core_clk_in);
		clk_en_in <= 1'b0;
		held = trace_position_out;
		ebu_core_model_inst.exec(15'h0050, 1'b1, 1'b0, 1'b0);
		chk(trace_position_out, held);
		chk(running_out, 1);
		@(posedge core_clk_in);
		clk_en_in <= 1'b1;
	endtask : t_stops
	initial begin
		repeat (16) @(posedge core_clk_in);
		rst_in <= 1'b0;
		t_addr;
		t_seq_data;
		t_stops;
		conclude;
	end
	initial begin
		#100000;
		errors++;
		conclude;
	end
endmodule : tb
`default_nettype wire
